// File: src/sfcc_pkg.sv
package sfcc_pkg;

  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_LOW_UPPER   = 6'h1b;
  localparam logic [5:0] IDX_LOW_LOWER   = 6'h1c;
  localparam logic [5:0] IDX_LIMIT_UPPER = 6'h1d;
  localparam logic [5:0] IDX_LIMIT_LOWER = 6'h1e;
  localparam logic [5:0] IDX_CLK_CTL     = 6'h1f;
  localparam logic [5:0] IDX_FNUM_LOWER  = 6'h30;
  localparam logic [5:0] IDX_FNUM_UPPER  = 6'h31;

  localparam logic [7:0] RST_LOW_UPPER   = 8'h00;
  localparam logic [7:0] RST_LOW_LOWER   = 8'h00;
  localparam logic [7:0] RST_LIMIT_UPPER = 8'h00;
  localparam logic [7:0] RST_LIMIT_LOWER = 8'h04;
  localparam logic [3:0] RST_CLK_CTL     = 4'h2;

  // serial_tx_clock_control fields; bits 7:4 are reserved and read zero
  localparam int CTL_OSC_BIT    = 3;
  localparam int CTL_HALF_BIT   = 2;
  localparam int CTL_SPEED_LSB  = 0;
  localparam int CTL_WIDTH      = 4;

  localparam logic [1:0] SPEED_1G5 = 2'h0;
  localparam logic [1:0] SPEED_1G2 = 2'h1;
  localparam logic [1:0] SPEED_800 = 2'h2;
  localparam logic [1:0] SPEED_400 = 2'h3;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [APB_AW-1:0]   paddr;
    logic [APB_DW-1:0]   pwdata;
  } apb_req_t;

  typedef struct packed {
    logic                pready;
    logic [APB_DW-1:0]   prdata;
    logic                pslverr;
  } apb_rsp_t;

endpackage

// File: src/frame_numberer.sv
`timescale 1ns/1ns
module frame_numberer #(
  parameter int NW = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          raw_mode,
  input  wire logic          frame_start,
  input  wire logic [NW-1:0] limit,
  output logic      [NW-1:0] number
);

  typedef struct packed {
    logic [NW-1:0] number;
  } num_state_t;

  num_state_t state_reg;
  num_state_t state_next;
  logic       step;

  assign step = raw_mode & frame_start;

  always_comb begin
    state_next = state_reg;
    // held between frame starts so the end packet reuses it
    if (step) begin
      if (limit == '0) begin
        state_next.number = '0;
      end else if (state_reg.number >= limit) begin
        state_next.number = NW'(1);
      end else begin
        state_next.number = state_reg.number + NW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign number = state_reg.number;

  property p_zero_limit;
    @(posedge pclk) disable iff (!presetn)
    ce && step && limit == '0 |=> number == '0;
  endproperty
  a_zero_limit: assert property (p_zero_limit) else $error("number not zero");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    ce && step && limit != '0 && number == limit |=> number == NW'(1);
  endproperty
  a_wrap: assert property (p_wrap) else $error("number did not wrap to one");

  property p_advance;
    @(posedge pclk) disable iff (!presetn)
    ce && step && limit != '0 && number < limit |=> number == $past(number) + NW'(1);
  endproperty
  a_advance: assert property (p_advance) else $error("number did not advance");

  property p_raw_only;
    @(posedge pclk) disable iff (!presetn)
    ce && frame_start && !raw_mode |=> $stable(number);
  endproperty
  a_raw_only: assert property (p_raw_only) else $error("number moved outside raw");

  property p_hold_frame;
    @(posedge pclk) disable iff (!presetn)
    !(ce && step) |=> $stable(number);
  endproperty
  a_hold_frame: assert property (p_hold_frame) else $error("number moved mid frame");

endmodule

// File: src/sync_frame_count_clock_regs.sv
// Function
// - low period is upper byte bits 15:8 and lower byte bits 7:0, RW, reset zero
// - in raw mode each frame gets a 16-bit number in start and end packets
// - limit zero disables numbering, number goes to zero at the next raw frame start
// - nonzero limit: number counts from one up to limit, then back to one
// - limit is two bytes, upper 15:8 lower 7:0, resets to four
// - oscillator select bit: zero external reference, one internal 200 MHz; reset zero
// - reference mode bit: zero 200 MHz, one 100 MHz; reset zero
// - two-bit speed field: 00 fastest, 01 1.2G, 10 800M, 11 400M; reset 10
// - hi/lo mode times phases apart; 50/50 uses one 24-bit period for both
`timescale 1ns/1ns
module sync_frame_count_clock_regs #(
  parameter int NW = 16
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  input  wire sfcc_pkg::apb_req_t   apb_req,
  output sfcc_pkg::apb_rsp_t        apb_rsp,
  input  wire logic                 raw_mode,
  input  wire logic                 frame_start,
  input  wire logic [15:0]          sync_high_period,
  input  wire logic                 sync_generation_style,
  input  wire logic                 sync_gen_enable,
  output logic                      frame_sync,
  output logic [15:0]               sync_low_period,
  output logic [NW-1:0]             frame_count_limit,
  output logic [NW-1:0]             frame_number,
  output logic                      internal_oscillator_select,
  output logic                      ref_clk_half_rate,
  output logic [1:0]                tx_speed
);

  typedef struct packed {
    logic [7:0]                     low_upper;
    logic [7:0]                     low_lower;
    logic [7:0]                     lim_upper;
    logic [7:0]                     lim_lower;
    logic [sfcc_pkg::CTL_WIDTH-1:0] clk_ctl;
    logic                           level;
    logic [23:0]                    phase_cnt;
    sfcc_pkg::apb_rsp_t             rsp;
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;
  logic        access;
  logic        commit;
  logic        aligned;
  logic [5:0]  idx;
  logic [23:0] phase_limit;
  logic [7:0]  rd_byte;
  logic        rd_err;

  assign access  = apb_req.psel & apb_req.penable;
  assign commit  = access & state_reg.rsp.pready;
  assign aligned = apb_req.paddr[1:0] == 2'h0;
  assign idx     = apb_req.paddr[7:2];

  // 50/50 joins high lower byte and both low bytes into one period
  assign phase_limit = sync_generation_style ?
                       {sync_high_period[7:0], state_reg.low_upper, state_reg.low_lower} :
                       (state_reg.level ? {8'h00, sync_high_period} :
                                          {8'h00, state_reg.low_upper, state_reg.low_lower});

  always_comb begin
    rd_err  = 1'b0;
    rd_byte = 8'h00;
    unique case (idx)
      sfcc_pkg::IDX_LOW_UPPER:   rd_byte = state_reg.low_upper;
      sfcc_pkg::IDX_LOW_LOWER:   rd_byte = state_reg.low_lower;
      sfcc_pkg::IDX_LIMIT_UPPER: rd_byte = state_reg.lim_upper;
      sfcc_pkg::IDX_LIMIT_LOWER: rd_byte = state_reg.lim_lower;
      sfcc_pkg::IDX_CLK_CTL:     rd_byte = {4'h0, state_reg.clk_ctl};
      sfcc_pkg::IDX_FNUM_LOWER:  rd_byte = frame_number[7:0];
      sfcc_pkg::IDX_FNUM_UPPER:  rd_byte = frame_number[15:8];
      default:                   rd_err  = 1'b1;
    endcase
    if (!aligned) begin
      rd_err  = 1'b1;
      rd_byte = 8'h00;
    end
  end

  always_comb begin
    state_next = state_reg;
    // one wait state: the answer is latched first, the write lands with pready
    if (access && !state_reg.rsp.pready) begin
      state_next.rsp.pready  = 1'b1;
      state_next.rsp.pslverr = rd_err;
      state_next.rsp.prdata  = apb_req.pwrite ? 32'h0 : {24'h0, rd_byte};
    end else begin
      state_next.rsp = '0;
    end
    if (commit && apb_req.pwrite && aligned) begin
      unique case (idx)
        sfcc_pkg::IDX_LOW_UPPER:   state_next.low_upper = apb_req.pwdata[7:0];
        sfcc_pkg::IDX_LOW_LOWER:   state_next.low_lower = apb_req.pwdata[7:0];
        sfcc_pkg::IDX_LIMIT_UPPER: state_next.lim_upper = apb_req.pwdata[7:0];
        sfcc_pkg::IDX_LIMIT_LOWER: state_next.lim_lower = apb_req.pwdata[7:0];
        // reserved upper bits are dropped
        sfcc_pkg::IDX_CLK_CTL:     state_next.clk_ctl = apb_req.pwdata[3:0];
        default:                   state_next.clk_ctl = state_reg.clk_ctl;
      endcase
    end
    // the generator opens with the low phase; >= guards a shrinking period
    if (!sync_gen_enable) begin
      state_next.level     = 1'b0;
      state_next.phase_cnt = 24'h0;
    end else if (state_reg.phase_cnt >= phase_limit) begin
      state_next.level     = ~state_reg.level;
      state_next.phase_cnt = 24'h0;
    end else begin
      state_next.phase_cnt = state_reg.phase_cnt + 24'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg           <= '0;
      state_reg.low_upper <= sfcc_pkg::RST_LOW_UPPER;
      state_reg.low_lower <= sfcc_pkg::RST_LOW_LOWER;
      state_reg.lim_upper <= sfcc_pkg::RST_LIMIT_UPPER;
      state_reg.lim_lower <= sfcc_pkg::RST_LIMIT_LOWER;
      state_reg.clk_ctl   <= sfcc_pkg::RST_CLK_CTL;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  frame_numberer #(
    .NW(NW)
  ) u_numberer (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .raw_mode    (raw_mode),
    .frame_start (frame_start),
    .limit       (frame_count_limit),
    .number      (frame_number)
  );

  assign apb_rsp                    = state_reg.rsp;
  assign frame_sync                 = state_reg.level;
  assign sync_low_period            = {state_reg.low_upper, state_reg.low_lower};
  assign frame_count_limit          = NW'({state_reg.lim_upper, state_reg.lim_lower});
  assign internal_oscillator_select = state_reg.clk_ctl[sfcc_pkg::CTL_OSC_BIT];
  assign ref_clk_half_rate          = state_reg.clk_ctl[sfcc_pkg::CTL_HALF_BIT];
  assign tx_speed = state_reg.clk_ctl[sfcc_pkg::CTL_SPEED_LSB +: 2];

  property p_low_bytes;
    @(posedge pclk) disable iff (!presetn)
    ce && commit && apb_req.pwrite && apb_req.paddr == {sfcc_pkg::IDX_LOW_LOWER, 2'h0}
      |=> sync_low_period[7:0] == $past(apb_req.pwdata[7:0]) && $stable(sync_low_period[15:8]);
  endproperty
  a_low_bytes: assert property (p_low_bytes) else $error("low byte write lost");

  property p_low_phase;
    @(posedge pclk) disable iff (!presetn)
    ce && sync_gen_enable && !sync_generation_style && !frame_sync
      && state_reg.phase_cnt == {8'h00, sync_low_period} |=> frame_sync;
  endproperty
  a_low_phase: assert property (p_low_phase) else $error("low phase length wrong");

  property p_low_hold;
    @(posedge pclk) disable iff (!presetn)
    ce && sync_gen_enable && !sync_generation_style && !frame_sync
      && state_reg.phase_cnt < {8'h00, sync_low_period} |=> !frame_sync;
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low phase ended early");

  property p_even_period;
    @(posedge pclk) disable iff (!presetn)
    ce && sync_gen_enable && sync_generation_style && frame_sync
      && state_reg.phase_cnt == {sync_high_period[7:0], sync_low_period} |=> !frame_sync;
  endproperty
  a_even_period: assert property (p_even_period) else $error("50/50 high phase wrong");

  property p_limit_reset;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> frame_count_limit == NW'(4) && tx_speed == sfcc_pkg::SPEED_800;
  endproperty
  a_limit_reset: assert property (p_limit_reset) else $error("reset values wrong");

  property p_osc_write;
    @(posedge pclk) disable iff (!presetn)
    ce && commit && apb_req.pwrite && apb_req.paddr == {sfcc_pkg::IDX_CLK_CTL, 2'h0}
      |=> internal_oscillator_select == $past(apb_req.pwdata[3]);
  endproperty
  a_osc_write: assert property (p_osc_write) else $error("oscillator select wrong");

  property p_half_write;
    @(posedge pclk) disable iff (!presetn)
    ce && commit && apb_req.pwrite && apb_req.paddr == {sfcc_pkg::IDX_CLK_CTL, 2'h0}
      |=> ref_clk_half_rate == $past(apb_req.pwdata[2]);
  endproperty
  a_half_write: assert property (p_half_write) else $error("reference mode wrong");

  property p_speed_write;
    @(posedge pclk) disable iff (!presetn)
    ce && commit && apb_req.pwrite && apb_req.paddr == {sfcc_pkg::IDX_CLK_CTL, 2'h0}
      |=> tx_speed == $past(apb_req.pwdata[1:0]) && apb_rsp.prdata == 32'h0;
  endproperty
  a_speed_write: assert property (p_speed_write) else $error("speed field wrong");

  property p_limit_write;
    @(posedge pclk) disable iff (!presetn)
    ce && commit && apb_req.pwrite && apb_req.paddr == {sfcc_pkg::IDX_LIMIT_UPPER, 2'h0}
      |=> frame_count_limit[15:8] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("limit upper wrong");

  property p_low_upper_write;
    @(posedge pclk) disable iff (!presetn)
    ce && commit && apb_req.pwrite && apb_req.paddr == {sfcc_pkg::IDX_LOW_UPPER, 2'h0}
      |=> sync_low_period[15:8] == $past(apb_req.pwdata[7:0]) && $stable(sync_low_period[7:0]);
  endproperty
  a_low_upper_write: assert property (p_low_upper_write) else $error("low upper lost");

  property p_limit_lower_write;
    @(posedge pclk) disable iff (!presetn)
    ce && commit && apb_req.pwrite && apb_req.paddr == {sfcc_pkg::IDX_LIMIT_LOWER, 2'h0}
      |=> frame_count_limit[7:0] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_limit_lower_write: assert property (p_limit_lower_write) else $error("limit lower wrong");

  // without a completed write the stored bytes never move
  property p_reg_idle;
    @(posedge pclk) disable iff (!presetn)
    !(ce && commit && apb_req.pwrite)
      |=> $stable(sync_low_period) && $stable(frame_count_limit);
  endproperty
  a_reg_idle: assert property (p_reg_idle) else $error("register moved without write");

  property p_ctl_idle;
    @(posedge pclk) disable iff (!presetn)
    !(ce && commit && apb_req.pwrite)
      |=> $stable(internal_oscillator_select) && $stable(ref_clk_half_rate)
          && $stable(tx_speed);
  endproperty
  a_ctl_idle: assert property (p_ctl_idle) else $error("control moved without write");

  property p_misaligned;
    @(posedge pclk) disable iff (!presetn)
    ce && commit && apb_req.pwrite && apb_req.paddr[1:0] != 2'h0
      |=> $stable(sync_low_period) && $stable(frame_count_limit);
  endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned write landed");

  property p_low_read;
    @(posedge pclk) disable iff (!presetn)
    ce && access && !apb_rsp.pready && !apb_req.pwrite
      && apb_req.paddr == {sfcc_pkg::IDX_LOW_UPPER, 2'h0}
      |=> apb_rsp.pready && apb_rsp.prdata == {24'h0, $past(sync_low_period[15:8])};
  endproperty
  a_low_read: assert property (p_low_read) else $error("low upper read wrong");

  property p_ctl_read;
    @(posedge pclk) disable iff (!presetn)
    ce && access && !apb_rsp.pready && !apb_req.pwrite
      && apb_req.paddr == {sfcc_pkg::IDX_CLK_CTL, 2'h0}
      |=> apb_rsp.prdata == {28'h0, $past(internal_oscillator_select), $past(ref_clk_half_rate),
                              $past(tx_speed)};
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read wrong");

  property p_high_phase;
    @(posedge pclk) disable iff (!presetn)
    ce && sync_gen_enable && !sync_generation_style && frame_sync
      && state_reg.phase_cnt == {8'h00, sync_high_period} |=> !frame_sync;
  endproperty
  a_high_phase: assert property (p_high_phase) else $error("high phase length wrong");

  property p_high_hold;
    @(posedge pclk) disable iff (!presetn)
    ce && sync_gen_enable && !sync_generation_style && frame_sync
      && state_reg.phase_cnt < {8'h00, sync_high_period} |=> frame_sync;
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high phase ended early");

  property p_even_low;
    @(posedge pclk) disable iff (!presetn)
    ce && sync_gen_enable && sync_generation_style && !frame_sync
      && state_reg.phase_cnt == {sync_high_period[7:0], sync_low_period} |=> frame_sync;
  endproperty
  a_even_low: assert property (p_even_low) else $error("50/50 low phase wrong");

  property p_gen_off;
    @(posedge pclk) disable iff (!presetn)
    ce && !sync_gen_enable |=> !frame_sync && state_reg.phase_cnt == 24'h0;
  endproperty
  a_gen_off: assert property (p_gen_off) else $error("generator not idle");

  property p_low_reset;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> sync_low_period == {sfcc_pkg::RST_LOW_UPPER, sfcc_pkg::RST_LOW_LOWER};
  endproperty
  a_low_reset: assert property (p_low_reset) else $error("low period reset wrong");

  property p_clock_reset;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !internal_oscillator_select && !ref_clk_half_rate;
  endproperty
  a_clock_reset: assert property (p_clock_reset) else $error("clock bits reset wrong");

endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               ce = 1'b1;
  sfcc_pkg::apb_req_t req = '0;
  sfcc_pkg::apb_rsp_t rsp;
  logic               raw_mode = 1'b0;
  logic               frame_start = 1'b0;
  logic [15:0]        sync_high_period = 16'h0000;
  logic               sync_generation_style = 1'b0;
  logic               sync_gen_enable = 1'b0;
  logic               frame_sync;
  logic [15:0]        sync_low_period;
  logic [15:0]        frame_count_limit;
  logic [15:0]        frame_number;
  logic               internal_oscillator_select;
  logic               ref_clk_half_rate;
  logic [1:0]         tx_speed;
  int                 fails = 0;
  int                 checked = 0;
  logic [31:0]        seed = 32'hc697;
  logic [31:0]        d;
  logic [31:0]        rd;
  logic               err;
  logic [15:0]        cur;
  logic [7:0]         v [5];
  logic [5:0]         idx [5];
  logic [7:0]         rst [5];

  always #50 pclk = ~pclk;

  sync_frame_count_clock_regs sync_frame_count_clock_regs_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req), .apb_rsp(rsp),
    .raw_mode(raw_mode), .frame_start(frame_start), .sync_high_period(sync_high_period),
    .sync_generation_style(sync_generation_style), .sync_gen_enable(sync_gen_enable),
    .frame_sync(frame_sync), .sync_low_period(sync_low_period),
    .frame_count_limit(frame_count_limit), .frame_number(frame_number),
    .internal_oscillator_select(internal_oscillator_select),
    .ref_clk_half_rate(ref_clk_half_rate), .tx_speed(tx_speed)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] next_number(input logic [15:0] c, input logic [15:0] lim);
    if (lim == 16'h0000) return 16'h0000;
    return (c >= lim) ? 16'h0001 : c + 16'h0001;
  endfunction

  function automatic logic [7:0] ra(input logic [5:0] i);
    return {i, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // request held until the edge that samples pready, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: no pready", $time);
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic pulse(input logic raw, input logic en);
    @(posedge pclk);
    raw_mode <= raw;
    ce <= en;
    frame_start <= 1'b1;
    @(posedge pclk);
    frame_start <= 1'b0;
    ce <= 1'b1;
    @(negedge pclk);
  endtask

  // counts whole phases from the first rise, so the generator must start from disabled
  task automatic measure(input int eh, input int el);
    int n;
    int hi;
    int lo;
    n = 0;
    hi = 0;
    lo = 0;
    while (frame_sync !== 1'b1 && n < 300) begin
      @(negedge pclk);
      n++;
    end
    while (frame_sync === 1'b1 && hi < 300) begin
      @(negedge pclk);
      hi++;
    end
    while (frame_sync !== 1'b1 && lo < 300) begin
      @(negedge pclk);
      lo++;
    end
    chk(hi, eh, "high phase");
    chk(lo, el, "low phase");
  endtask

  task automatic end_sim();
    $display("counts: %0d checked, %0d failed", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    idx = '{sfcc_pkg::IDX_LOW_UPPER, sfcc_pkg::IDX_LOW_LOWER, sfcc_pkg::IDX_LIMIT_UPPER,
            sfcc_pkg::IDX_LIMIT_LOWER, sfcc_pkg::IDX_CLK_CTL};
    rst = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h02};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(frame_count_limit, 16'h0004, "limit port");
    chk(tx_speed, 2'h2, "speed port");
    chk(frame_number, 16'h0000, "number port");
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra(idx[i]), 32'h0);
      chk(rd, {24'h0, rst[i]}, "reset value");
    end
    $display("test reset done");
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 5; i++) begin
        seed = lfsr_next(seed);
        d = seed;
        if (i == 4 && d[1:0] == 2'h3) d[2] = 1'b0;
        v[i] = d[7:0];
        apb(1'b1, ra(idx[i]), d);
      end
      for (int i = 0; i < 5; i++) begin
        apb(1'b0, ra(idx[i]), 32'h0);
        chk(rd, {24'h0, v[i] & ((i == 4) ? 8'h0f : 8'hff)}, "readback");
      end
      chk(sync_low_period, {v[0], v[1]}, "low period");
      chk(frame_count_limit, {v[2], v[3]}, "limit");
    end
    for (int k = 0; k < 16; k++) begin
      if (k[2] && k[1:0] == 2'h3) continue;
      apb(1'b1, ra(sfcc_pkg::IDX_CLK_CTL), {24'h0, 4'hf, k[3:0]});
      apb(1'b0, ra(sfcc_pkg::IDX_CLK_CTL), 32'h0);
      chk(rd, {28'h0, k[3:0]}, "ctl readback");
      chk(tx_speed, k[1:0], "speed");
      chk(ref_clk_half_rate, k[2], "half rate");
      chk(internal_oscillator_select, k[3], "osc select");
    end
    apb(1'b0, 8'h80, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, 8'h71, 32'h5a);
    chk(err, 1'b1, "misaligned write");
    chk(sync_low_period, {v[0], v[1]}, "misaligned ignored");
    $display("test registers done");
    apb(1'b1, ra(sfcc_pkg::IDX_LIMIT_UPPER), 32'h0);
    apb(1'b1, ra(sfcc_pkg::IDX_LIMIT_LOWER), 32'h3);
    cur = 16'h0000;
    for (int f = 0; f < 14; f++) begin
      seed = lfsr_next(seed);
      pulse(seed[0] | seed[1], seed[2] | seed[3]);
      if ((seed[0] | seed[1]) && (seed[2] | seed[3])) cur = next_number(cur, 16'h0003);
      chk(frame_number, cur, "frame number");
      @(negedge pclk);
      chk(frame_number, cur, "number holds");
    end
    @(posedge pclk);
    raw_mode <= 1'b1;
    frame_start <= 1'b1;
    repeat (2) @(posedge pclk);
    frame_start <= 1'b0;
    cur = next_number(next_number(cur, 16'h0003), 16'h0003);
    @(negedge pclk);
    chk(frame_number, cur, "back to back");
    apb(1'b0, 8'hc0, 32'h0);
    chk(rd, {24'h0, cur[7:0]}, "number status");
    apb(1'b1, ra(sfcc_pkg::IDX_LIMIT_LOWER), 32'h0);
    pulse(1'b1, 1'b1);
    chk(frame_number, 16'h0000, "limit zero");
    pulse(1'b1, 1'b1);
    chk(frame_number, 16'h0000, "limit zero again");
    $display("test numbering done");
    apb(1'b1, ra(sfcc_pkg::IDX_LOW_UPPER), 32'h0);
    apb(1'b1, ra(sfcc_pkg::IDX_LOW_LOWER), 32'h2);
    @(posedge pclk);
    sync_high_period <= 16'h0001;
    sync_gen_enable <= 1'b1;
    measure(2, 3);
    @(posedge pclk);
    sync_gen_enable <= 1'b0;
    sync_generation_style <= 1'b1;
    sync_high_period <= 16'hff00;
    apb(1'b1, ra(sfcc_pkg::IDX_LOW_LOWER), 32'h1);
    @(posedge pclk);
    sync_gen_enable <= 1'b1;
    measure(2, 2);
    $display("test generator done");
    end_sim();
  end
endmodule
